// *** design/ief_ctrl.sv ***
// Interrupt and event flag controller with APB register access
// What this block does
// - 24 interrupt flags: high holds 23..16, mid 15..8, low 7..0.
// - Flag bits read their state; writing one clears that flag alone.
// - Reset clears every interrupt flag.
// - Per-level enable registers, same bit as flag, one enables, reset zero.
// - Interrupt code register gives highest pending source, resets to all ones.
// - Interrupt summary: bit 2 high, bit 1 mid, bit 0 low; rest zero.
// - Eight event sources: four high level, four low level.
// - Each event level drives one core event input.
// - Event request stays latched after its source goes inactive.
// - Event flag sets only on enabled rising edge of its source.
// - Writing one clears an event flag; writing zero leaves it.
// - Reset clears every event flag.
// - Event code register gives highest set event, all ones when none.
// - Event code and summary follow latched flags, not raw sources.
// - Interrupt flag sets only on enabled rising edge of its source.
// - Interrupt code register reads all ones when no flag set.
// - Each interrupt level drives one core interrupt input.
// - Event summary: bit 1 any high event, bit 0 any low event.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module ief_ctrl #(
  parameter int unsigned NUM_INT = ief_pkg::IEF_NUM_INT,
  parameter int unsigned NUM_EVT = ief_pkg::IEF_NUM_EVT
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Request lines from peripherals
  input  wire logic [NUM_INT-1:0]    int_src,
  input  wire logic [NUM_EVT-1:0]    evt_src,
  // Level lines to the processor core
  output ief_pkg::ief_core_lvl_s     core_lvl
);
  ief_pkg::ief_top_st_s st_q;
  ief_pkg::ief_top_st_s st_d;

  logic [NUM_INT-1:0] int_flags;
  logic [NUM_EVT-1:0] evt_flags;
  logic [NUM_INT-1:0] int_clr;
  logic [NUM_EVT-1:0] evt_clr;
  logic [7:0]         int_code_w;
  logic [7:0]         evt_code_w;
  logic               access;
  logic               fire;
  logic               wr_fire;

  // Word read of a register; unmapped addresses flag an error
  function automatic logic [32:0] read_word(
    input logic [7:0]           addr,
    input ief_pkg::ief_top_st_s s,
    input logic [23:0]          iflg,
    input logic [7:0]           eflg
  );
    logic [32:0] r;
    r = 33'h000000000;
    case (addr)
      ief_pkg::IEF_OFF_INT_FLAGS_HIGH: r[7:0] = iflg[23:16];
      ief_pkg::IEF_OFF_INT_FLAGS_MID:  r[7:0] = iflg[15:8];
      ief_pkg::IEF_OFF_INT_FLAGS_LOW:  r[7:0] = iflg[7:0];
      ief_pkg::IEF_OFF_INT_EN_HIGH:    r[7:0] = s.int_en[23:16];
      ief_pkg::IEF_OFF_INT_EN_MID:     r[7:0] = s.int_en[15:8];
      ief_pkg::IEF_OFF_INT_EN_LOW:     r[7:0] = s.int_en[7:0];
      ief_pkg::IEF_OFF_INT_TOP_CODE:   r[7:0] = s.int_code;
      ief_pkg::IEF_OFF_INT_SUMMARY:    r[2:0] = s.int_sum;
      ief_pkg::IEF_OFF_EVT_FLAGS:      r[7:0] = eflg;
      ief_pkg::IEF_OFF_EVT_ENABLE:     r[7:0] = s.evt_en;
      ief_pkg::IEF_OFF_EVT_TOP_CODE:   r[7:0] = s.evt_code;
      ief_pkg::IEF_OFF_EVT_SUMMARY:    r[1:0] = s.evt_sum;
      default:                         r[32] = 1'b1;
    endcase
    return r;
  endfunction

  // Edge capture and flag storage
  ief_flag_bank #(
    .WIDTH (NUM_INT)
  ) u_int_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (int_src),
    .enable  (st_q.int_en),
    .clear   (int_clr),
    .flags   (int_flags)
  );

  ief_flag_bank #(
    .WIDTH (NUM_EVT)
  ) u_evt_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (evt_src),
    .enable  (st_q.evt_en),
    .clear   (evt_clr),
    .flags   (evt_flags)
  );

  // Codes come from latched flags so a clear also moves the code
  ief_top_code #(
    .WIDTH (NUM_INT)
  ) u_int_code (
    .flags (int_flags),
    .code  (int_code_w)
  );

  ief_top_code #(
    .WIDTH (NUM_EVT)
  ) u_evt_code (
    .flags (evt_flags),
    .code  (evt_code_w)
  );

  // One wait state lets prdata come straight from a flip-flop
  assign access  = psel & penable;
  assign fire    = access & st_q.pready;
  assign wr_fire = fire & pwrite;

  always_comb begin
    logic [32:0] rd;
    rd      = read_word(paddr, st_q, int_flags, evt_flags);
    st_d    = st_q;
    int_clr = '0;
    evt_clr = '0;

    // Bus handshake
    st_d.pready = access & ~st_q.pready;
    if (access & ~st_q.pready) begin
      st_d.prdata  = pwrite ? 32'h00000000 : rd[31:0];
      st_d.pslverr = rd[32];
    end else if (fire) begin
      st_d.pslverr = 1'b0;
    end

    // Writes land at the completing edge only
    if (wr_fire) begin
      case (paddr)
        ief_pkg::IEF_OFF_INT_FLAGS_HIGH: begin
          int_clr[23:16] = pwdata[7:0];
        end
        ief_pkg::IEF_OFF_INT_FLAGS_MID: begin
          int_clr[15:8] = pwdata[7:0];
        end
        ief_pkg::IEF_OFF_INT_FLAGS_LOW: begin
          int_clr[7:0] = pwdata[7:0];
        end
        ief_pkg::IEF_OFF_INT_EN_HIGH: begin
          st_d.int_en[23:16] = pwdata[7:0];
        end
        ief_pkg::IEF_OFF_INT_EN_MID: begin
          st_d.int_en[15:8] = pwdata[7:0];
        end
        ief_pkg::IEF_OFF_INT_EN_LOW: begin
          st_d.int_en[7:0] = pwdata[7:0];
        end
        ief_pkg::IEF_OFF_EVT_FLAGS: begin
          evt_clr = pwdata[7:0];
        end
        ief_pkg::IEF_OFF_EVT_ENABLE: begin
          st_d.evt_en = pwdata[7:0];
        end
        // Read-only and unmapped words ignore writes
        default: begin
          st_d.evt_en = st_q.evt_en;
        end
      endcase
    end

    // Codes, summaries and level lines
    st_d.int_code = int_code_w;
    st_d.evt_code = evt_code_w;
    st_d.int_sum  = {|int_flags[23:16], |int_flags[15:8], |int_flags[7:0]};
    st_d.evt_sum  = {|evt_flags[7:4], |evt_flags[3:0]};
    st_d.lvl.core_interrupt_input_a = st_d.int_sum[2];
    st_d.lvl.core_interrupt_input_b = st_d.int_sum[1];
    st_d.lvl.core_interrupt_input_c = st_d.int_sum[0];
    st_d.lvl.core_event_input_a     = st_d.evt_sum[1];
    st_d.lvl.core_event_input_b     = st_d.evt_sum[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= '0;
      st_q.int_en   <= ief_pkg::IEF_INT_EN_RST;
      st_q.evt_en   <= ief_pkg::IEF_EVT_EN_RST;
      st_q.int_code <= ief_pkg::IEF_CODE_NONE;
      st_q.evt_code <= ief_pkg::IEF_CODE_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata   = st_q.prdata;
  assign pready   = st_q.pready;
  assign pslverr  = st_q.pslverr;
  assign core_lvl = st_q.lvl;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_int_code_none: assert property (
    (int_flags == '0) |=> (st_q.int_code == 8'hFF))
    else $error("interrupt code not all ones while idle");

  chk_int_code_max: assert property (
    (int_flags != '0) |=>
      (($past(int_flags) >> st_q.int_code) == 24'h000001))
    else $error("interrupt code is not the largest pending source");

  chk_evt_code_max: assert property (
    (evt_flags != '0) |=>
      (($past(evt_flags) >> st_q.evt_code) == 8'h01))
    else $error("event code is not the largest set event");

  chk_evt_code_none: assert property (
    (evt_flags == '0) |=> (st_q.evt_code == 8'hFF))
    else $error("event code not all ones with no flag");

  chk_int_summary: assert property (
    1'b1 |=> (st_q.int_sum == {|$past(int_flags[23:16]),
                               |$past(int_flags[15:8]),
                               |$past(int_flags[7:0])}))
    else $error("interrupt summary disagrees with flags");

  chk_evt_summary: assert property (
    1'b1 |=> (st_q.evt_sum == {|$past(evt_flags[7:4]),
                               |$past(evt_flags[3:0])}))
    else $error("event summary disagrees with flags");

  chk_int_levels: assert property (
    1'b1 |=> ({core_lvl.core_interrupt_input_a, core_lvl.core_interrupt_input_b,
               core_lvl.core_interrupt_input_c} == {|$past(int_flags[23:16]),
                                                    |$past(int_flags[15:8]),
                                                    |$past(int_flags[7:0])}))
    else $error("interrupt level lines differ from flags");

  chk_evt_levels: assert property (
    1'b1 |=> ({core_lvl.core_event_input_a, core_lvl.core_event_input_b} ==
              {|$past(evt_flags[7:4]), |$past(evt_flags[3:0])}))
    else $error("event level lines differ from flags");

  chk_level_drop: assert property (
    (wr_fire && paddr == ief_pkg::IEF_OFF_INT_FLAGS_LOW &&
     pwdata[7:0] == 8'hFF && int_src == '0 && $past(int_src) == '0 &&
     $past(int_src, 2) == '0)
      |=> ##1 !core_lvl.core_interrupt_input_c)
    else $error("low interrupt level stayed up after full clear");

  chk_en_write: assert property (
    (wr_fire && paddr == ief_pkg::IEF_OFF_INT_EN_HIGH)
      |=> (st_q.int_en[23:16] == $past(pwdata[7:0])))
    else $error("interrupt enable write not stored");

  chk_high_map: assert property (
    (access && !pready && !pwrite &&
     paddr == ief_pkg::IEF_OFF_INT_FLAGS_HIGH)
      |=> (prdata == {24'h000000, $past(int_flags[23:16])}))
    else $error("high flag register not mapped to sources 23..16");

  chk_apb_wait: assert property (
    (access && !pready) |=> pready ##1 !pready)
    else $error("access phase not answered after one wait");

  chk_bad_addr_err: assert property (
    (access && !pready && (paddr[1:0] != 2'b00 || paddr > ief_pkg::IEF_OFF_EVT_SUMMARY))
      |=> (pready && pslverr))
    else $error("unmapped address answered without error");

  chk_good_addr_ok: assert property (
    (access && !pready && paddr[1:0] == 2'b00 && paddr <= ief_pkg::IEF_OFF_EVT_SUMMARY)
      |=> !pslverr)
    else $error("mapped address answered with error");

  chk_wr_rdata_zero: assert property (
    (access && !pready && pwrite) |=> (prdata == 32'h00000000))
    else $error("write returned nonzero read data");

  chk_pready_idle: assert property (
    !access |=> !pready)
    else $error("ready raised outside an access phase");

  chk_en_mid_write: assert property (
    (wr_fire && paddr == ief_pkg::IEF_OFF_INT_EN_MID)
      |=> (st_q.int_en[15:8] == $past(pwdata[7:0])))
    else $error("mid interrupt enable write not stored");

  chk_en_low_write: assert property (
    (wr_fire && paddr == ief_pkg::IEF_OFF_INT_EN_LOW)
      |=> (st_q.int_en[7:0] == $past(pwdata[7:0])))
    else $error("low interrupt enable write not stored");

  chk_evt_en_write: assert property (
    (wr_fire && paddr == ief_pkg::IEF_OFF_EVT_ENABLE)
      |=> (st_q.evt_en == $past(pwdata[7:0])))
    else $error("event enable write not stored");

  chk_mid_map: assert property (
    (access && !pready && !pwrite && paddr == ief_pkg::IEF_OFF_INT_FLAGS_MID)
      |=> (prdata == {24'h000000, $past(int_flags[15:8])}))
    else $error("mid flag register not mapped to sources 15..8");

  chk_low_map: assert property (
    (access && !pready && !pwrite && paddr == ief_pkg::IEF_OFF_INT_FLAGS_LOW)
      |=> (prdata == {24'h000000, $past(int_flags[7:0])}))
    else $error("low flag register not mapped to sources 7..0");

  chk_evt_map: assert property (
    (access && !pready && !pwrite && paddr == ief_pkg::IEF_OFF_EVT_FLAGS)
      |=> (prdata == {24'h000000, $past(evt_flags)}))
    else $error("event flag register does not read latched flags");

  chk_code_read: assert property (
    (access && !pready && !pwrite && paddr == ief_pkg::IEF_OFF_INT_TOP_CODE)
      |=> (prdata == {24'h000000, $past(st_q.int_code)}))
    else $error("interrupt code register read mismatch");

  chk_sum_read: assert property (
    (access && !pready && !pwrite && paddr == ief_pkg::IEF_OFF_INT_SUMMARY)
      |=> (prdata == {29'h00000000, $past(st_q.int_sum)}))
    else $error("interrupt summary read has stray bits");

  chk_evt_sum_read: assert property (
    (access && !pready && !pwrite && paddr == ief_pkg::IEF_OFF_EVT_SUMMARY)
      |=> (prdata == {30'h00000000, $past(st_q.evt_sum)}))
    else $error("event summary read has stray bits");

  chk_low_level_up: assert property (
    (int_flags[7:0] != 8'h00) |=> core_lvl.core_interrupt_input_c)
    else $error("low interrupt level not raised by a pending flag");

endmodule // ief_ctrl
`default_nettype wire

// *** design/ief_flag_bank.sv ***
// Flag bank: source synchroniser, rising edge detect and write-one-to-clear flags
`timescale 1ns/100ps
`default_nettype none
module ief_flag_bank #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Sources and control
  input  wire logic [WIDTH-1:0] src,
  input  wire logic [WIDTH-1:0] enable,
  input  wire logic [WIDTH-1:0] clear,
  // Latched flags
  output logic      [WIDTH-1:0] flags
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] flags;
  } ief_bank_st_s;

  ief_bank_st_s     st_q;
  ief_bank_st_s     st_d;
  logic [WIDTH-1:0] set;

  always_comb begin
    st_d      = st_q;
    st_d.meta = src;
    st_d.sync = st_q.meta;
    st_d.last = st_q.sync;
    set       = st_q.sync & ~st_q.last & enable;
    // Set beats a clear in the same cycle so no edge is lost
    st_d.flags = (st_q.flags & ~clear) | set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_set_cause: assert property (
    1'b1 |=> ((st_q.flags & ~$past(st_q.flags) & ~$past(set)) == '0))
    else $error("flag rose without an enabled source edge");
  chk_clear_one: assert property (
    ((clear & ~set) != '0) |=> ((st_q.flags & $past(clear & ~set)) == '0))
    else $error("written one did not clear the flag");
  chk_set_wins: assert property (
    (set != '0) |=> ((st_q.flags & $past(set)) == $past(set)))
    else $error("edge lost against a clear");
  chk_flag_holds: assert property (
    1'b1 |=> (($past(st_q.flags) & ~$past(clear) & ~st_q.flags) == '0))
    else $error("flag dropped without a clear");

endmodule // ief_flag_bank
`default_nettype wire

// *** design/ief_pkg.sv ***
// Package: register map, reset values and carrier types of the flag controller
package ief_pkg;

  // Source counts
  localparam int unsigned IEF_NUM_INT   = 24;
  localparam int unsigned IEF_NUM_EVT   = 8;
  localparam int unsigned IEF_LVL_W     = 8;
  localparam int unsigned IEF_EVT_LVL_W = 4;

  // Byte addresses of the registers
  localparam logic [7:0] IEF_OFF_INT_FLAGS_HIGH = 8'h00;
  localparam logic [7:0] IEF_OFF_INT_FLAGS_MID  = 8'h04;
  localparam logic [7:0] IEF_OFF_INT_FLAGS_LOW  = 8'h08;
  localparam logic [7:0] IEF_OFF_INT_EN_HIGH    = 8'h0C;
  localparam logic [7:0] IEF_OFF_INT_EN_MID     = 8'h10;
  localparam logic [7:0] IEF_OFF_INT_EN_LOW     = 8'h14;
  localparam logic [7:0] IEF_OFF_INT_TOP_CODE   = 8'h18;
  localparam logic [7:0] IEF_OFF_INT_SUMMARY    = 8'h1C;
  localparam logic [7:0] IEF_OFF_EVT_FLAGS      = 8'h20;
  localparam logic [7:0] IEF_OFF_EVT_ENABLE     = 8'h24;
  localparam logic [7:0] IEF_OFF_EVT_TOP_CODE   = 8'h28;
  localparam logic [7:0] IEF_OFF_EVT_SUMMARY    = 8'h2C;

  // Values after reset
  localparam logic [7:0]  IEF_CODE_NONE = 8'hFF;
  localparam logic [23:0] IEF_INT_EN_RST = 24'h000000;
  localparam logic [7:0]  IEF_EVT_EN_RST = 8'h00;

  // Level lines towards the processor core
  typedef struct packed {
    logic core_interrupt_input_a;
    logic core_interrupt_input_b;
    logic core_interrupt_input_c;
    logic core_event_input_a;
    logic core_event_input_b;
  } ief_core_lvl_s;

  // Complete state of the top module
  typedef struct packed {
    logic [23:0]   int_en;
    logic [7:0]    evt_en;
    logic [7:0]    int_code;
    logic [7:0]    evt_code;
    logic [2:0]    int_sum;
    logic [1:0]    evt_sum;
    ief_core_lvl_s lvl;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
  } ief_top_st_s;

endpackage

// *** design/ief_top_code.sv ***
// Highest pending source number, all ones when nothing is pending
`timescale 1ns/100ps
`default_nettype none
module ief_top_code #(
  parameter int unsigned WIDTH = 8
) (
  // Latched flags
  input  wire logic [WIDTH-1:0] flags,
  // Source number
  output logic      [7:0]       code
);
  // Later hits overwrite earlier ones, so the largest number wins
  always_comb begin
    code = ief_pkg::IEF_CODE_NONE;
    for (int i = 0; i < WIDTH; i++) begin
      if (flags[i]) begin
        code = 8'(i);
      end
    end
  end

endmodule // ief_top_code
`default_nettype wire

// *** sim/ief_core_model.sv ***
// Processor core model: counts assertions of its interrupt and event level inputs
`timescale 1ns/100ps
`default_nettype none
module ief_core_model (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Level inputs from the flag controller
  input  wire ief_pkg::ief_core_lvl_s core_lvl,
  // Level assertions seen so far
  output logic      [7:0]             n_rises
);
  logic [4:0] last_q;

  // One input per priority level, each watched on its own
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q  <= 5'h00;
      n_rises <= 8'h00;
    end else begin
      last_q  <= core_lvl;
      n_rises <= n_rises + 8'($countones(core_lvl & ~last_q));
    end
  end
endmodule // ief_core_model
`default_nettype wire

// *** sim/ief_ctrl_tb_top.sv ***
// Self-checking testbench of the interrupt and event flag controller
`timescale 1ns/100ps
`default_nettype none
module ief_ctrl_tb_top;
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [23:0]           int_src;
  logic [7:0]            evt_src;
  ief_pkg::ief_core_lvl_s core_lvl;
  logic [7:0]            n_rises;
  int                    err_count;
  int                    n_checks;

  ief_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_src(int_src), .evt_src(evt_src), .core_lvl(core_lvl));

  ief_core_model core_u (.pclk(pclk), .presetn(presetn), .core_lvl(core_lvl),
    .n_rises(n_rises));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready, read data and error are all taken at the completing rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    bit done;
    done = 1'b0;
    rd   = 32'h00000000;
    err  = 1'b0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        rd   = prdata;
        err  = pslverr;
        done = 1'b1;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      err_count++;
      $display("Error pready expected 1 seen 0");
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 8'h00, rd, e);
    chk(what, {24'h000000, exp}, rd);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic lvl_chk(input logic [4:0] exp);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("core_lvl", {27'h0, exp}, {27'h0, core_lvl});
  endtask

  task automatic t_reset_values();
    logic [7:0] a [12];
    logic [7:0] v [12];
    a = '{ief_pkg::IEF_OFF_INT_FLAGS_HIGH, ief_pkg::IEF_OFF_INT_FLAGS_MID,
          ief_pkg::IEF_OFF_INT_FLAGS_LOW, ief_pkg::IEF_OFF_INT_EN_HIGH,
          ief_pkg::IEF_OFF_INT_EN_MID, ief_pkg::IEF_OFF_INT_EN_LOW,
          ief_pkg::IEF_OFF_INT_TOP_CODE, ief_pkg::IEF_OFF_INT_SUMMARY,
          ief_pkg::IEF_OFF_EVT_FLAGS, ief_pkg::IEF_OFF_EVT_ENABLE,
          ief_pkg::IEF_OFF_EVT_TOP_CODE, ief_pkg::IEF_OFF_EVT_SUMMARY};
    v = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
    for (int i = 0; i < 12; i++) begin
      rd_chk("reset value", a[i], v[i]);
    end
    lvl_chk(5'h00);
  endtask

  task automatic t_enable_rw();
    wr(ief_pkg::IEF_OFF_INT_EN_HIGH, 8'hA5);
    wr(ief_pkg::IEF_OFF_INT_EN_MID, 8'h5A);
    wr(ief_pkg::IEF_OFF_INT_EN_LOW, 8'h81);
    wr(ief_pkg::IEF_OFF_EVT_ENABLE, 8'h3C);
    rd_chk("int_en_high", ief_pkg::IEF_OFF_INT_EN_HIGH, 8'hA5);
    rd_chk("int_en_mid", ief_pkg::IEF_OFF_INT_EN_MID, 8'h5A);
    rd_chk("int_en_low", ief_pkg::IEF_OFF_INT_EN_LOW, 8'h81);
    rd_chk("evt_en", ief_pkg::IEF_OFF_EVT_ENABLE, 8'h3C);
  endtask

  task automatic t_interrupts();
    wr(ief_pkg::IEF_OFF_INT_EN_HIGH, 8'h01);
    wr(ief_pkg::IEF_OFF_INT_EN_MID, 8'h02);
    wr(ief_pkg::IEF_OFF_INT_EN_LOW, 8'h04);
    // Source 23 stays disabled, its edge must be dropped
    int_src <= 24'h810204;
    repeat (6) @(posedge pclk);
    rd_chk("int_flags_high", ief_pkg::IEF_OFF_INT_FLAGS_HIGH, 8'h01);
    rd_chk("int_flags_mid", ief_pkg::IEF_OFF_INT_FLAGS_MID, 8'h02);
    rd_chk("int_flags_low", ief_pkg::IEF_OFF_INT_FLAGS_LOW, 8'h04);
    rd_chk("int_code", ief_pkg::IEF_OFF_INT_TOP_CODE, 8'h10);
    rd_chk("int_sum", ief_pkg::IEF_OFF_INT_SUMMARY, 8'h07);
    lvl_chk(5'h1C);
    wr(ief_pkg::IEF_OFF_INT_EN_HIGH, 8'h81);
    wr(ief_pkg::IEF_OFF_INT_FLAGS_HIGH, 8'h01);
    rd_chk("int_flags_high", ief_pkg::IEF_OFF_INT_FLAGS_HIGH, 8'h00);
    rd_chk("int_code", ief_pkg::IEF_OFF_INT_TOP_CODE, 8'h09);
    rd_chk("int_sum", ief_pkg::IEF_OFF_INT_SUMMARY, 8'h03);
    // Quiet sources so the full low clear below drops its level line
    int_src <= 24'h000000;
    lvl_chk(5'h0C);
    wr(ief_pkg::IEF_OFF_INT_FLAGS_MID, 8'h02);
    wr(ief_pkg::IEF_OFF_INT_FLAGS_LOW, 8'hFF);
    rd_chk("int_code", ief_pkg::IEF_OFF_INT_TOP_CODE, 8'hFF);
    rd_chk("int_sum", ief_pkg::IEF_OFF_INT_SUMMARY, 8'h00);
    lvl_chk(5'h00);
  endtask

  task automatic t_events();
    logic [31:0] rd;
    logic        e;
    wr(ief_pkg::IEF_OFF_EVT_ENABLE, 8'h22);
    evt_src <= 8'h62;
    repeat (2) @(posedge pclk);
    evt_src <= 8'h00;
    repeat (6) @(posedge pclk);
    rd_chk("evt_flags", ief_pkg::IEF_OFF_EVT_FLAGS, 8'h22);
    rd_chk("evt_code", ief_pkg::IEF_OFF_EVT_TOP_CODE, 8'h05);
    rd_chk("evt_sum", ief_pkg::IEF_OFF_EVT_SUMMARY, 8'h03);
    lvl_chk(5'h03);
    wr(ief_pkg::IEF_OFF_EVT_FLAGS, 8'h00);
    rd_chk("evt_flags", ief_pkg::IEF_OFF_EVT_FLAGS, 8'h22);
    wr(ief_pkg::IEF_OFF_EVT_FLAGS, 8'h20);
    rd_chk("evt_code", ief_pkg::IEF_OFF_EVT_TOP_CODE, 8'h01);
    rd_chk("evt_sum", ief_pkg::IEF_OFF_EVT_SUMMARY, 8'h01);
    lvl_chk(5'h01);
    chk("core rises", 32'h00000005, {24'h000000, n_rises});
    apb(1'b0, 8'h30, 8'h00, rd, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, rd);
  endtask

  initial begin
    err_count = 0;
    n_checks  = 0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h00000000;
    int_src   = 24'h000000;
    evt_src   = 8'h00;
    do_reset();
    t_reset_values();
    t_enable_rw();
    t_interrupts();
    t_events();
    // Second reset with an event flag still pending
    do_reset();
    t_reset_values();
    end_of_test();
  end
endmodule // ief_ctrl_tb_top
`default_nettype wire
